// ---- rtl/cfg_bank_pkg.sv ----
// Constants shared by the converter mode/configuration register bank.
// Assumes a 25 MHz system clock and an APB master with 32-bit data.
package cfg_bank_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 25;
    localparam int WAKE_TIME_US = 100;
    localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_FREQ_MHZ;
    localparam int WAKE_CNT_W = 12;

    // ----------------------------------------------------------------
    // Register map: printed offsets are indexes, byte address = 4 * index
    // ----------------------------------------------------------------
    localparam int NUM_REGS = 14;
    localparam logic [7:0] PERF_TUNE_A_IDX = 8'h02;
    localparam logic [7:0] OFFSET_LOOP_ENABLE_IDX = 8'h3d;
    localparam logic [7:0] POWER_CONTROL_IDX = 8'h45;
    localparam logic [7:0] CHAN_B_HIGH_FREQ_IDX = 8'h4a;
    localparam logic [7:0] CHAN_A_HIGH_FREQ_IDX = 8'h58;
    localparam logic [7:0] CHAN_A_OFFSET_PEDESTAL_IDX = 8'hbf;
    localparam logic [7:0] CHAN_B_OFFSET_PEDESTAL_IDX = 8'hc1;
    localparam logic [7:0] OFFSET_LOOP_CONTROL_IDX = 8'hcf;
    localparam logic [7:0] PERF_TUNE_B_IDX = 8'hd5;
    localparam logic [7:0] PERF_TUNE_C_IDX = 8'hd7;
    localparam logic [7:0] PERF_TUNE_D_CHAN_B_SLOW_IDX = 8'hdb;
    localparam logic [7:0] SLOW_MODE_GATE_IDX = 8'hef;
    localparam logic [7:0] SWING_CONTROL_GATE_IDX = 8'hf1;
    localparam logic [7:0] CHAN_A_SLOW_MODE_IDX = 8'hf2;

    localparam logic [7:0] REG_INDEX [NUM_REGS] = '{
        PERF_TUNE_A_IDX, OFFSET_LOOP_ENABLE_IDX, POWER_CONTROL_IDX,
        CHAN_B_HIGH_FREQ_IDX, CHAN_A_HIGH_FREQ_IDX,
        CHAN_A_OFFSET_PEDESTAL_IDX, CHAN_B_OFFSET_PEDESTAL_IDX,
        OFFSET_LOOP_CONTROL_IDX, PERF_TUNE_B_IDX, PERF_TUNE_C_IDX,
        PERF_TUNE_D_CHAN_B_SLOW_IDX, SLOW_MODE_GATE_IDX,
        SWING_CONTROL_GATE_IDX, CHAN_A_SLOW_MODE_IDX
    };

    // Storage slots, same order as REG_INDEX
    localparam int SLOT_PERF_A = 0;
    localparam int SLOT_LOOP_EN = 1;
    localparam int SLOT_POWER = 2;
    localparam int SLOT_B_HF = 3;
    localparam int SLOT_A_HF = 4;
    localparam int SLOT_A_PED = 5;
    localparam int SLOT_B_PED = 6;
    localparam int SLOT_LOOP_CTL = 7;
    localparam int SLOT_PERF_B = 8;
    localparam int SLOT_PERF_C = 9;
    localparam int SLOT_PERF_D = 10;
    localparam int SLOT_SLOW_GATE = 11;
    localparam int SLOT_SWING = 12;
    localparam int SLOT_A_SLOW = 13;

    localparam logic [7:0] REG_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int FULL_POWER_DOWN_BIT = 2;
    localparam int OFFSET_LOOP_ENABLE_BIT = 5;
    localparam int FAST_INPUT_BIT = 0;
    localparam int PEDESTAL_LSB = 4;
    localparam int PEDESTAL_W = 4;
    localparam int HOLD_ESTIMATE_BIT = 7;
    localparam int TAU_LSB = 2;
    localparam int TAU_W = 4;
    localparam int SLOW_GATE_BIT = 4;
    localparam int CHAN_A_SLOW_BIT = 3;
    localparam int CHAN_B_SLOW_BIT = 0;
    localparam int SWING_GATE_LSB = 0;
    localparam logic [1:0] SWING_GATE_ON = 2'h3;
    localparam int PERF_BIT_3 = 6;
    localparam int PERF_BIT_4 = 4;
    localparam int PERF_BIT_5 = 3;
    localparam int PERF_BIT_6 = 3;
    localparam int PERF_BIT_7 = 2;
    localparam int PERF_BIT_8 = 5;

    // ----------------------------------------------------------------
    // Data path
    // ----------------------------------------------------------------
    localparam int SAMPLE_W = 12;
    localparam int ACC_W = 28;
    localparam logic [11:0] MIDCODE = 12'h800;

endpackage

// ---- rtl/wake_timer.sv ----
// Recovery timer for the full power-down state.
// Assumes the power-down level comes from a register on the same clock.
`timescale 1ns/1ps
`default_nettype none
module wake_timer
    import cfg_bank_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic power_down,
    output logic awake
);

    logic [WAKE_CNT_W-1:0] count_r;

    // ----------------------------------------------------------------
    // Count out the wake-up time after power-down is released
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            count_r <= '0;
        end else if (power_down) begin
            count_r <= WAKE_CNT_W'(WAKE_CYCLES);
        end else if (count_r != '0) begin
            count_r <= count_r - WAKE_CNT_W'(1);
        end
    end

    assign awake = !power_down && (count_r == '0);

endmodule
`default_nettype wire

// ---- rtl/offset_loop.sv ----
// First-order offset correction loop for one converter channel.
// Assumes samples are offset binary and arrive every clock.
`timescale 1ns/1ps
`default_nettype none
module offset_loop
    import cfg_bank_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic hold,
    input wire logic [TAU_W-1:0] tau,
    input wire logic [PEDESTAL_W-1:0] pedestal,
    input wire logic [SAMPLE_W-1:0] sample,
    output logic [SAMPLE_W-1:0] corrected
);

    logic signed [ACC_W-1:0] acc_r;
    logic signed [ACC_W-1:0] estimate;
    logic [SAMPLE_W-1:0] target;
    logic [SAMPLE_W-1:0] fixed;
    logic signed [SAMPLE_W-1:0] err;

    // Pedestal is two's complement around midcode
    assign target = MIDCODE + {{(SAMPLE_W-PEDESTAL_W){pedestal[PEDESTAL_W-1]}}, pedestal};
    // Gain of 2^-tau sets the loop time constant in clock cycles
    assign estimate = acc_r >>> tau;
    assign fixed = sample - estimate[SAMPLE_W-1:0];
    assign err = signed'(fixed - target);

    // ----------------------------------------------------------------
    // Estimator: cleared while off, kept while held
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn || !enable) begin
            acc_r <= '0;
        end else if (!hold) begin
            acc_r <= acc_r + ACC_W'(err);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            corrected <= '0;
        end else begin
            corrected <= enable ? fixed : sample;
        end
    end

endmodule
`default_nettype wire

// ---- rtl/cfg_bank.sv ----
// Mode and configuration register bank of a dual-channel converter,
// with the offset correction loops and power-down recovery it steers.
// Assumes an APB master on clk and converter samples on the same clock.
//
// Behaviour
// (RULE_01) Power-down bit stops channels, references, outputs; wake takes 100 us.
// (RULE_02) Bit 0 of 4Ah and 58h select fast input mode per channel.
// (RULE_03) Enabled correction loop converges output to midcode.
// (RULE_04) Signed 4-bit pedestal in bits 7:4 shifts the converged target.
// (RULE_05) Hold bit freezes estimate; last estimate still applied every cycle.
// (RULE_06) Software enables correction whenever it uses the hold bit.
// (RULE_07) Bits 5:2 of Offset_loop_control set loop time constant.
// (RULE_08) Slow-mode gate at zero forces slow mode off for both channels.
// (RULE_09) Per-channel slow bits act only with gate set; software sets gate first.
// (RULE_10) Swing gate 11 enables register swing control, 00 disables; 01, 10 unused.
// (RULE_11) Above 160 MSPS software sets all six tuning bits.
// (RULE_12) Software writes zero to unassigned bits.
// (RULE_13) Every register resets to 00h.
// (RULE_14) Correction runs only while enable bit 5 of 3Dh is one.
// (RULE_15) Registers hold last written value until rewritten or reset; reads return it.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module cfg_bank
    import cfg_bank_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [cfg_bank_pkg::SAMPLE_W-1:0] chan_a_sample,
    input wire logic [cfg_bank_pkg::SAMPLE_W-1:0] chan_b_sample,
    output logic [cfg_bank_pkg::SAMPLE_W-1:0] chan_a_corrected,
    output logic [cfg_bank_pkg::SAMPLE_W-1:0] chan_b_corrected,
    output logic full_power_down,
    output logic converter_ready,
    output logic chan_a_fast_input_mode,
    output logic chan_b_fast_input_mode,
    output logic chan_a_slow_enable,
    output logic chan_b_slow_enable,
    output logic swing_reg_control,
    output logic perf_tune_all,
    output logic offset_loop_on
);
    import cfg_bank_pkg::*;

    // ----------------------------------------------------------------
    // Storage and decode signals
    // ----------------------------------------------------------------
    logic [7:0] regs_r [NUM_REGS];
    logic [7:0] access_idx;
    logic addr_ok;
    logic [NUM_REGS-1:0] slot_hit;
    logic hit;
    logic [7:0] read_byte;
    logic setup_phase;
    logic write_take;
    logic awake;
    logic loop_enable;
    logic loop_hold;
    logic [TAU_W-1:0] loop_tau;
    logic [SAMPLE_W-1:0] a_fixed;
    logic [SAMPLE_W-1:0] b_fixed;
    logic [SAMPLE_W-1:0] chan_a_in;
    logic [SAMPLE_W-1:0] chan_b_in;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Word aligned only; upper bits outside the map are unmapped
    assign access_idx = paddr[9:2];
    assign addr_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);

    generate
        for (genvar i = 0; i < NUM_REGS; i++) begin : g_slot
            assign slot_hit[i] = addr_ok && (access_idx == REG_INDEX[i]);

            // Only the low byte lane carries data
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    regs_r[i] <= REG_RESET; // [RULE_13]
                end else if (write_take && slot_hit[i] && pstrb[0]) begin
                    regs_r[i] <= pwdata[7:0]; // [RULE_15]
                end
            end
        end
    endgenerate

    assign hit = |slot_hit;

    always_comb begin
        read_byte = 8'h00;
        for (int k = 0; k < NUM_REGS; k++) begin
            if (slot_hit[k]) begin
                read_byte = regs_r[k]; // [RULE_15]
            end
        end
    end

    // ----------------------------------------------------------------
    // APB handshake
    // ----------------------------------------------------------------
    // One-cycle access phase: ready rises for the cycle after setup
    assign setup_phase = psel && !penable;
    assign write_take = psel && penable && pready && pwrite && !pslverr;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_phase;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup_phase && !hit;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase && !pwrite && hit) begin
            prdata <= {24'h00_0000, read_byte};
        end else if (setup_phase) begin
            prdata <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Power down and recovery
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            full_power_down <= 1'b0;
        end else begin
            full_power_down <= regs_r[SLOT_POWER][FULL_POWER_DOWN_BIT]; // [RULE_01]
        end
    end

    // Analog recovery is slow, so readiness lags the release
    wake_timer u_wake (
        .clk(clk),
        .resetn(resetn),
        .power_down(full_power_down),
        .awake(awake)
    );

    always_ff @(posedge clk) begin
        if (!resetn) begin
            converter_ready <= 1'b0;
        end else begin
            converter_ready <= awake; // [RULE_01]
        end
    end

    // ----------------------------------------------------------------
    // Input frequency modes
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            chan_a_fast_input_mode <= 1'b0;
            chan_b_fast_input_mode <= 1'b0;
        end else begin
            chan_a_fast_input_mode <= regs_r[SLOT_A_HF][FAST_INPUT_BIT]; // [RULE_02]
            chan_b_fast_input_mode <= regs_r[SLOT_B_HF][FAST_INPUT_BIT]; // [RULE_02]
        end
    end

    // ----------------------------------------------------------------
    // Low-speed mode
    // ----------------------------------------------------------------
    // Channel bits are ignored until the gate is set
    always_ff @(posedge clk) begin
        if (!resetn) begin
            chan_a_slow_enable <= 1'b0;
        end else begin
            chan_a_slow_enable <= regs_r[SLOT_SLOW_GATE][SLOW_GATE_BIT] // [RULE_08]
                && regs_r[SLOT_A_SLOW][CHAN_A_SLOW_BIT]; // [RULE_09]
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            chan_b_slow_enable <= 1'b0;
        end else begin
            chan_b_slow_enable <= regs_r[SLOT_SLOW_GATE][SLOW_GATE_BIT] // [RULE_08]
                && regs_r[SLOT_PERF_D][CHAN_B_SLOW_BIT]; // [RULE_09]
        end
    end

    // ----------------------------------------------------------------
    // Output swing gate
    // ----------------------------------------------------------------
    // Unused codes fall back to the safe, disabled state
    always_ff @(posedge clk) begin
        if (!resetn) begin
            swing_reg_control <= 1'b0;
        end else begin
            swing_reg_control <= (regs_r[SLOT_SWING][SWING_GATE_LSB +: 2] == SWING_GATE_ON); // [RULE_10]
        end
    end

    // ----------------------------------------------------------------
    // High-performance tuning
    // ----------------------------------------------------------------
    // Status only; setting them is up to software
    always_ff @(posedge clk) begin
        if (!resetn) begin
            perf_tune_all <= 1'b0;
        end else begin
            perf_tune_all <= regs_r[SLOT_PERF_A][PERF_BIT_3]
                && regs_r[SLOT_PERF_B][PERF_BIT_4]
                && regs_r[SLOT_PERF_B][PERF_BIT_5]
                && regs_r[SLOT_PERF_C][PERF_BIT_6]
                && regs_r[SLOT_PERF_C][PERF_BIT_7]
                && regs_r[SLOT_PERF_D][PERF_BIT_8]; // [RULE_11]
        end
    end

    // ----------------------------------------------------------------
    // Offset correction
    // ----------------------------------------------------------------
    // Loops are parked while powered down so they restart clean
    assign loop_enable = regs_r[SLOT_LOOP_EN][OFFSET_LOOP_ENABLE_BIT] && !full_power_down; // [RULE_14]
    // Hold has no effect unless the loop is enabled
    assign loop_hold = regs_r[SLOT_LOOP_CTL][HOLD_ESTIMATE_BIT]; // [RULE_05] [RULE_06]
    assign loop_tau = regs_r[SLOT_LOOP_CTL][TAU_LSB +: TAU_W]; // [RULE_07]

    // Outputs idle at zero while the buffers are off
    assign chan_a_in = full_power_down ? '0 : chan_a_sample;
    assign chan_b_in = full_power_down ? '0 : chan_b_sample;

    offset_loop u_loop_a (
        .clk(clk),
        .resetn(resetn),
        .enable(loop_enable),
        .hold(loop_hold),
        .tau(loop_tau),
        .pedestal(regs_r[SLOT_A_PED][PEDESTAL_LSB +: PEDESTAL_W]), // [RULE_04]
        .sample(chan_a_in),
        .corrected(a_fixed) // [RULE_03]
    );

    offset_loop u_loop_b (
        .clk(clk),
        .resetn(resetn),
        .enable(loop_enable),
        .hold(loop_hold),
        .tau(loop_tau),
        .pedestal(regs_r[SLOT_B_PED][PEDESTAL_LSB +: PEDESTAL_W]), // [RULE_04]
        .sample(chan_b_in),
        .corrected(b_fixed) // [RULE_03]
    );

    always_ff @(posedge clk) begin
        if (!resetn) begin
            chan_a_corrected <= '0;
            chan_b_corrected <= '0;
        end else if (full_power_down) begin
            chan_a_corrected <= '0; // [RULE_01]
            chan_b_corrected <= '0; // [RULE_01]
        end else begin
            chan_a_corrected <= a_fixed;
            chan_b_corrected <= b_fixed;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            offset_loop_on <= 1'b0;
        end else begin
            offset_loop_on <= loop_enable; // [RULE_14]
        end
    end

endmodule
`default_nettype wire

// ---- tb/cfg_bank_properties.sv ----
// Checker for the converter mode register bank.
// Assumes it is bound to cfg_bank and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cfg_bank_properties
    import cfg_bank_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic full_power_down,
    input wire logic converter_ready,
    input wire logic chan_a_fast_input_mode,
    input wire logic chan_b_fast_input_mode,
    input wire logic chan_a_slow_enable,
    input wire logic chan_b_slow_enable,
    input wire logic swing_reg_control,
    input wire logic perf_tune_all,
    input wire logic offset_loop_on
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    logic [11:0] wake_cnt_r;
    wire wr_done = psel && penable && pready && pwrite && pstrb[0];
    // Counts only the wake-up stretch, so a stuck timer shows up
    always_ff @(posedge clk) begin
        if (!resetn || full_power_down || converter_ready) begin
            wake_cnt_r <= 12'h000;
        end else begin
            wake_cnt_r <= wake_cnt_r + 12'h001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_pready;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_pready: assert property (p_pready) else $error("pready not one cycle after setup");
    property p_power_down;
        wr_done && paddr == {2'h0, POWER_CONTROL_IDX, 2'h0} |-> ##2 full_power_down == $past(pwdata[2], 2);
    endproperty
    a_power_down: assert property (p_power_down) else $error("power-down level wrong");
    property p_wake_hold;
        $fell(full_power_down) |-> !converter_ready [*8];
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("ready too soon after power-up");
    property p_wake_bound;
        wake_cnt_r < 12'd2600;
    endproperty
    a_wake_bound: assert property (p_wake_bound) else $error("wake-up took too long");
    property p_fast_a;
        wr_done && paddr == {2'h0, CHAN_A_HIGH_FREQ_IDX, 2'h0} |-> ##2 chan_a_fast_input_mode == $past(pwdata[0], 2);
    endproperty
    a_fast_a: assert property (p_fast_a) else $error("channel A fast mode wrong");
    property p_slow_gate;
        wr_done && paddr == {2'h0, SLOW_MODE_GATE_IDX, 2'h0} && !pwdata[4] |-> ##2 !chan_a_slow_enable && !chan_b_slow_enable;
    endproperty
    a_slow_gate: assert property (p_slow_gate) else $error("slow mode on with gate off");
    property p_swing;
        wr_done && paddr == {2'h0, SWING_CONTROL_GATE_IDX, 2'h0}
            |-> ##2 swing_reg_control == ($past(pwdata[1:0], 2) == SWING_GATE_ON);
    endproperty
    a_swing: assert property (p_swing) else $error("swing control state wrong");
    property p_refuse;
        psel && !penable && paddr[1:0] != 2'h0 |=> pslverr && pready && (pwrite || prdata == 32'h0);
    endproperty
    a_refuse: assert property (p_refuse) else $error("misaligned access not refused");
    property p_reset_zero;
        $rose(resetn) |-> !full_power_down && !chan_a_fast_input_mode && !chan_b_fast_input_mode
            && !swing_reg_control && !perf_tune_all && !offset_loop_on;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("mode output set after reset");
endmodule
bind cfg_bank cfg_bank_properties chk (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .full_power_down(full_power_down), .converter_ready(converter_ready),
    .chan_a_fast_input_mode(chan_a_fast_input_mode), .chan_b_fast_input_mode(chan_b_fast_input_mode),
    .chan_a_slow_enable(chan_a_slow_enable), .chan_b_slow_enable(chan_b_slow_enable),
    .swing_reg_control(swing_reg_control), .perf_tune_all(perf_tune_all), .offset_loop_on(offset_loop_on));
`default_nettype wire

// ---- tb/apb_host.sv ----
// Host side of the register bus: an APB master with one transfer task.
// Assumes the bank answers with pready; every wait is bounded.
`timescale 1ns/1ps
`default_nettype none
module apb_host (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ----------------------------------------------------------------
    // Transfer
    // ----------------------------------------------------------------
    int timeouts = 0;
    logic [31:0] rdata;
    logic rerr;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end
    task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= 4'hf;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge clk);
        end
        if (n == 16) timeouts++;
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pstrb <= 4'h0;
        // Released lines must not keep looking valid
        paddr <= ~a;
        pwdata <= ~{24'h0, d};
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ---- tb/tb_cfg_bank.sv ----
// Self-checking bench for the converter mode register bank.
// Assumes the apb_host model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_cfg_bank;
    import cfg_bank_pkg::*;
    // ----------------------------------------------------------------
    // Harness
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [SAMPLE_W-1:0] samp_a = 12'h812;
    logic [SAMPLE_W-1:0] samp_b = 12'h7f0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [SAMPLE_W-1:0] corr_a, corr_b;
    logic fpd, rdy, fast_a, fast_b, slow_a, slow_b, swing, perf, loop_on;
    int num_errors = 0;
    int n_tests = 0;
    int n;
    // Assigned field bits of each register, in REG_INDEX order
    localparam logic [7:0] FIELD_MASK [NUM_REGS] = '{8'h40, 8'h20, 8'h04, 8'h01, 8'h01, 8'hf0, 8'hf0,
        8'hbc, 8'h18, 8'h0c, 8'h21, 8'h10, 8'h03, 8'h08};
    always #20 clk = ~clk;
    apb_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    cfg_bank DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_a_sample(samp_a), .chan_b_sample(samp_b), .chan_a_corrected(corr_a),
        .chan_b_corrected(corr_b), .full_power_down(fpd), .converter_ready(rdy),
        .chan_a_fast_input_mode(fast_a), .chan_b_fast_input_mode(fast_b), .chan_a_slow_enable(slow_a),
        .chan_b_slow_enable(slow_b), .swing_reg_control(swing), .perf_tune_all(perf),
        .offset_loop_on(loop_on));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [32:0] exp, input logic [32:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: expected %h, got %h", $time, exp, got);
        end
    endtask
    task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
        host.xfer(a, w, d);
        if (host.timeouts != 0) begin
            num_errors++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus({2'h0, idx, 2'h0}, 1'b1, d);
    endtask
    task automatic verify_regs(input logic zero);
        for (int i = 0; i < NUM_REGS; i++) begin
            bus({2'h0, REG_INDEX[i], 2'h0}, 1'b0, 8'h00);
            check({25'h0, zero ? 8'h00 : FIELD_MASK[i]}, {host.rerr, host.rdata});
        end
    endtask
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        verify_regs(1'b1);
        $display("reset values done");
        wr(SLOW_MODE_GATE_IDX, 8'h10);
        for (int i = 0; i < NUM_REGS; i++) wr(REG_INDEX[i], FIELD_MASK[i]);
        verify_regs(1'b0);
        check(33'h17e, {24'h0, fpd, rdy, fast_a, fast_b, slow_a, slow_b, swing, perf, loop_on});
        check(33'h0, {9'h0, corr_a, corr_b});
        $display("readback and modes done");
        wr(SLOW_MODE_GATE_IDX, 8'h00);
        wr(SWING_CONTROL_GATE_IDX, 8'h00);
        wr(PERF_TUNE_C_IDX, 8'h08);
        @(posedge clk);
        check(33'h0, {29'h0, slow_a, slow_b, swing, perf});
        bus({2'h0, CHAN_A_SLOW_MODE_IDX, 2'h0}, 1'b0, 8'h00);
        check(33'h08, {host.rerr, host.rdata});
        $display("gates done");
        wr(POWER_CONTROL_IDX, 8'h00);
        n = 0;
        while (rdy !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        check(33'h1, {32'h0, n >= 2490 && n <= 2510});
        if (n == 3000) finish_test();
        wr(CHAN_A_OFFSET_PEDESTAL_IDX, 8'h70);
        wr(CHAN_B_OFFSET_PEDESTAL_IDX, 8'h80);
        wr(OFFSET_LOOP_CONTROL_IDX, 8'h08);
        repeat (300) @(posedge clk);
        check(33'h8077f8, {9'h0, corr_a, corr_b});
        wr(OFFSET_LOOP_CONTROL_IDX, 8'h88);
        samp_a <= 12'h832;
        repeat (50) @(posedge clk);
        check(33'h8277f8, {9'h0, corr_a, corr_b});
        wr(OFFSET_LOOP_ENABLE_IDX, 8'h00);
        repeat (10) @(posedge clk);
        check(33'h8327f0, {8'h0, loop_on, corr_a, corr_b});
        $display("offset loop done");
        bus(12'h00c, 1'b0, 8'h00);
        check(33'h100000000, {host.rerr, host.rdata});
        bus(12'h009, 1'b1, 8'hff);
        check(33'h100000000, {host.rerr, 32'h0});
        $display("refusals done");
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        verify_regs(1'b1);
        $display("second reset done");
        finish_test();
    end
endmodule
`default_nettype wire
